/* File: rtl/pta_analyzer.sv */
// Pulse timing analysis over stored samples, plus interrupt selection.
// Assumes the sample memory returns data one cycle after the address and
// that all command and event inputs are synchronous one-cycle pulses.
`default_nettype none

// Function
// - High means sample above absolute zero
// - Selector G: max, min, mean high time
// - Selector L: max, min, mean low time
// - Selector P: max, min, mean period
// - Selector F: max, min, mean frequency
// - Selector D: duty is high*100/period
// - Count 1 to depth, default full span
// - Per-value stream, 2000 values, delimited
// - Start within depth, default oldest sample (record base in record form)
// - Selector picks exactly one interrupt condition
// - Selection without letter means measurement complete
// - Trigger command enables, analysis needs none
// - Request held until acknowledge or reset
// - Armed fires on command, and also needs external arm when that is programmed
// - Analysis condition fires on each analysis end
// - Measurement condition fires after sampling ends
// - Record and trigger conditions fire each time
// - Status byte active low except bit 6
module pta_analyzer (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Analysis command
  input wire logic i_cmd_start,
  input wire pta_pkg::pta_cmd_t i_cmd,
  input wire logic [7:0] i_delimiter,
  input wire logic i_delimiter_wr,
  // Acquisition memory context
  input wire logic [pta_pkg::ADDR_W-1:0] i_oldest_addr,
  input wire logic [pta_pkg::ADDR_W-1:0] i_record_size,
  output logic [pta_pkg::ADDR_W-1:0] o_mem_addr,
  output logic o_mem_rd,
  input wire logic signed [pta_pkg::SAMPLE_W-1:0] i_mem_data,
  // Results
  output logic o_busy,
  output logic o_done,
  output pta_pkg::pta_result_t o_result,
  output logic o_val_valid,
  output logic [pta_pkg::VAL_W-1:0] o_val_data,
  output logic [7:0] o_val_delim,
  // Interrupt selection and acquisition events
  input wire logic i_irq_sel_wr,
  input wire logic i_irq_sel_given,
  input wire pta_pkg::pta_irq_cond_t i_irq_sel,
  input wire logic i_trigger_cmd,
  input wire logic i_ext_arm_prog,
  input wire logic i_ext_arm,
  input wire logic i_ev_triggered,
  input wire logic i_ev_meas_done,
  input wire logic i_ev_record_done,
  input wire logic i_irq_ack,
  output logic o_irq_req,
  output logic [7:0] o_status
);
  import pta_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_SAMPLE, S_DIVIDE, S_UPDATE, S_MEAN, S_FINISH
  } pta_state_t;

  pta_state_t state_reg;
  pta_cmd_t cmd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [CNT_W-1:0] left_reg;
  logic first_reg, level_reg, edge_seen_reg, have_high_reg;
  logic [VAL_W-1:0] run_reg, high_last_reg, val_reg;
  logic [VAL_W-1:0] max_reg, min_reg;
  logic [SUM_W-1:0] sum_reg;
  logic [CNT_W-1:0] n_reg;
  logic [11:0] sent_reg;
  logic [SUM_W-1:0] quot_reg;
  logic [VAL_W:0] rem_reg;
  logic [VAL_W-1:0] dvs_reg;
  logic [5:0] step_reg;
  logic div_mean_reg;
  logic ana_done_ev;

  // Sample classification against zero, never the waveform midpoint
  function automatic logic is_high(input logic signed [SAMPLE_W-1:0] s);
    is_high = (s > $signed({SAMPLE_W{1'b0}}));
  endfunction

  function automatic logic [CNT_W-1:0] clamp_count(
      input logic given, input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] dflt);
    if (!given || c == '0 || c > CNT_W'(MEM_DEPTH)) begin
      clamp_count = dflt;
    end else begin
      clamp_count = c;
    end
  endfunction

  logic [ADDR_W-1:0] rec_base;
  logic [ADDR_W-1:0] first_addr;
  logic [CNT_W-1:0] first_count;
  logic [2*ADDR_W-1:0] rec_prod;
  logic sample_high;
  logic [VAL_W-1:0] period_sum;
  logic [VAL_W:0] rem_shift;

  always_comb begin
    rec_prod = ADDR_W'(i_cmd.record_num) * i_record_size;
    rec_base = rec_prod[ADDR_W-1:0];
    if (i_cmd.record_form) begin
      first_addr = rec_base +
        (i_cmd.start_given ? i_cmd.start[ADDR_W-1:0] : '0);
      first_count = clamp_count(i_cmd.count_given, i_cmd.count,
        {1'b0, i_record_size});
    end else begin
      // Negative offsets wrap around the circular memory
      first_addr = i_cmd.start_given ? i_cmd.start[ADDR_W-1:0]
                                     : i_oldest_addr;
      first_count = clamp_count(i_cmd.count_given, i_cmd.count,
        CNT_W'(MEM_DEPTH));
    end
    sample_high = is_high(i_mem_data);
    period_sum = high_last_reg + run_reg;
    rem_shift = {rem_reg[VAL_W-1:0], quot_reg[SUM_W-1]};
  end

  // Sequencer and interval measurement
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
      cmd_reg <= '0;
      addr_reg <= '0;
      left_reg <= '0;
      first_reg <= 1'b0;
      level_reg <= 1'b0;
      edge_seen_reg <= 1'b0;
      have_high_reg <= 1'b0;
      run_reg <= '0;
      high_last_reg <= '0;
      val_reg <= '0;
      quot_reg <= '0;
      rem_reg <= '0;
      dvs_reg <= '0;
      step_reg <= '0;
      div_mean_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (i_cmd_start) begin
            cmd_reg <= i_cmd;
            addr_reg <= first_addr;
            left_reg <= first_count;
            first_reg <= 1'b1;
            edge_seen_reg <= 1'b0;
            have_high_reg <= 1'b0;
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: state_reg <= S_SAMPLE;
        S_SAMPLE: begin
          addr_reg <= addr_reg + 1'b1;
          left_reg <= left_reg - 1'b1;
          first_reg <= 1'b0;
          level_reg <= sample_high;
          state_reg <= (left_reg == CNT_W'(1)) ? S_MEAN : S_FETCH;
          if (first_reg || sample_high == level_reg) begin
            run_reg <= first_reg ? VAL_W'(1) : run_reg + 1'b1;
          end else begin
            run_reg <= VAL_W'(1);
            edge_seen_reg <= 1'b1;
            if (level_reg && edge_seen_reg) begin
              high_last_reg <= run_reg;
              have_high_reg <= 1'b1;
              if (cmd_reg.sel == PTA_SEL_HIGH) begin
                val_reg <= run_reg;
                state_reg <= S_UPDATE;
              end
            end else if (!level_reg && edge_seen_reg) begin
              if (cmd_reg.sel == PTA_SEL_LOW) begin
                val_reg <= run_reg;
                state_reg <= S_UPDATE;
              end else if (have_high_reg) begin
                unique case (cmd_reg.sel)
                  PTA_SEL_PERIOD: begin
                    val_reg <= period_sum;
                    state_reg <= S_UPDATE;
                  end
                  PTA_SEL_FREQ: begin
                    quot_reg <= SUM_W'(SAMPLE_RATE_HZ);
                    dvs_reg <= period_sum;
                    rem_reg <= '0;
                    step_reg <= '0;
                    div_mean_reg <= 1'b0;
                    state_reg <= S_DIVIDE;
                  end
                  PTA_SEL_DUTY: begin
                    quot_reg <= SUM_W'(high_last_reg * DUTY_SCALE);
                    dvs_reg <= period_sum;
                    rem_reg <= '0;
                    step_reg <= '0;
                    div_mean_reg <= 1'b0;
                    state_reg <= S_DIVIDE;
                  end
                  default: ;
                endcase
              end
            end
          end
        end
        S_DIVIDE: begin
          // Restoring division, one quotient bit per cycle to save area
          if (rem_shift >= {1'b0, dvs_reg}) begin
            rem_reg <= rem_shift - {1'b0, dvs_reg};
            quot_reg <= {quot_reg[SUM_W-2:0], 1'b1};
          end else begin
            rem_reg <= rem_shift;
            quot_reg <= {quot_reg[SUM_W-2:0], 1'b0};
          end
          step_reg <= step_reg + 1'b1;
          if (step_reg == DIV_STEPS - 1'b1) begin
            state_reg <= div_mean_reg ? S_FINISH : S_UPDATE;
          end
        end
        S_UPDATE: begin
          state_reg <= (left_reg == '0) ? S_MEAN : S_FETCH;
        end
        S_MEAN: begin
          if (n_reg == '0) begin
            quot_reg <= '0;
            state_reg <= S_FINISH;
          end else begin
            quot_reg <= sum_reg;
            dvs_reg <= VAL_W'(n_reg);
            rem_reg <= '0;
            step_reg <= '0;
            div_mean_reg <= 1'b1;
            state_reg <= S_DIVIDE;
          end
        end
        S_FINISH: state_reg <= S_IDLE;
      endcase
    end
  end

  // Per-cycle value, taken from the divider when one was needed
  logic [VAL_W-1:0] upd_val;
  always_comb begin
    upd_val = (cmd_reg.sel == PTA_SEL_FREQ || cmd_reg.sel == PTA_SEL_DUTY)
              ? quot_reg[VAL_W-1:0] : val_reg;
  end

  // Statistics and per-value stream
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      max_reg <= '0;
      min_reg <= '1;
      sum_reg <= '0;
      n_reg <= '0;
      sent_reg <= '0;
      o_val_valid <= 1'b0;
      o_val_data <= '0;
      o_val_delim <= DELIM_RESET;
    end else begin
      o_val_valid <= 1'b0;
      if (i_delimiter_wr) begin
        o_val_delim <= i_delimiter;
      end
      if (state_reg == S_IDLE && i_cmd_start) begin
        max_reg <= '0;
        min_reg <= '1;
        sum_reg <= '0;
        n_reg <= '0;
        sent_reg <= '0;
      end else if (state_reg == S_UPDATE) begin
        if (upd_val > max_reg) begin
          max_reg <= upd_val;
        end
        if (upd_val < min_reg) begin
          min_reg <= upd_val;
        end
        sum_reg <= sum_reg + SUM_W'(upd_val);
        n_reg <= n_reg + 1'b1;
        // Later values are still counted but no longer streamed
        if (cmd_reg.per_value && sent_reg < VAL_LIMIT) begin
          o_val_valid <= 1'b1;
          o_val_data <= upd_val;
          sent_reg <= sent_reg + 1'b1;
        end
      end
    end
  end

  // Published results
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_result <= '0;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_mem_addr <= '0;
      o_mem_rd <= 1'b0;
      ana_done_ev <= 1'b0;
    end else begin
      o_done <= (state_reg == S_FINISH);
      ana_done_ev <= (state_reg == S_FINISH);
      o_busy <= (state_reg != S_IDLE) && (state_reg != S_FINISH);
      o_mem_rd <= 1'b0;
      if ((state_reg == S_IDLE && i_cmd_start) ||
          ((state_reg == S_SAMPLE || state_reg == S_UPDATE) &&
           left_reg != '0)) begin
        o_mem_rd <= 1'b1;
      end
      o_mem_addr <= (state_reg == S_IDLE) ? first_addr
                  : (state_reg == S_SAMPLE) ? addr_reg + 1'b1 : addr_reg;
      if (state_reg == S_FINISH) begin
        o_result.max <= max_reg;
        o_result.min <= (n_reg == '0) ? '0 : min_reg;
        o_result.avg <= quot_reg[VAL_W-1:0];
        o_result.count <= n_reg;
      end
    end
  end

  // Interrupt condition selection and arming
  pta_irq_cond_t cond_reg;
  logic enabled_reg, cmd_armed_reg, armed_reg;
  logic fl_meas_reg, fl_trig_reg, fl_arm_reg, fl_ana_reg, fl_rec_reg;
  logic armed_now, armed_ev, cond_hit;

  always_comb begin
    armed_now = cmd_armed_reg && (!i_ext_arm_prog || i_ext_arm);
    armed_ev = armed_now && !armed_reg;
    unique case (cond_reg)
      PTA_IRQ_ARMED: cond_hit = enabled_reg && armed_ev;
      PTA_IRQ_ANALYSIS: cond_hit = ana_done_ev;
      PTA_IRQ_MEAS: cond_hit = enabled_reg && i_ev_meas_done;
      PTA_IRQ_RECORD: cond_hit = enabled_reg && i_ev_record_done;
      PTA_IRQ_TRIG: cond_hit = enabled_reg && i_ev_triggered;
      default: cond_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cond_reg <= PTA_IRQ_DISABLE;
      enabled_reg <= 1'b0;
      cmd_armed_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_now;
      if (i_irq_sel_wr) begin
        // One condition at a time; a new selection other than analysis waits for a trigger
        cond_reg <= i_irq_sel_given ? i_irq_sel : PTA_IRQ_MEAS;
        enabled_reg <= 1'b0;
      end else if (i_trigger_cmd) begin
        enabled_reg <= 1'b1;
      end
      if (i_trigger_cmd) begin
        cmd_armed_reg <= 1'b1;
      end else if (i_ev_meas_done) begin
        cmd_armed_reg <= 1'b0;
      end
    end
  end

  // Request and sticky status; a new event wins over acknowledge
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_irq_req <= 1'b0;
      fl_meas_reg <= 1'b0;
      fl_trig_reg <= 1'b0;
      fl_arm_reg <= 1'b0;
      fl_ana_reg <= 1'b0;
      fl_rec_reg <= 1'b0;
    end else begin
      if (cond_hit) begin
        o_irq_req <= 1'b1;
      end else if (i_irq_ack) begin
        o_irq_req <= 1'b0;
      end
      fl_meas_reg <= i_ev_meas_done || (fl_meas_reg && !i_trigger_cmd);
      fl_trig_reg <= i_ev_triggered || (fl_trig_reg && !i_trigger_cmd);
      fl_arm_reg <= armed_ev || (fl_arm_reg && !i_trigger_cmd);
      fl_rec_reg <= i_ev_record_done || (fl_rec_reg && !i_trigger_cmd);
      fl_ana_reg <= ana_done_ev ||
        (fl_ana_reg && !(state_reg == S_IDLE && i_cmd_start));
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_status <= STB_RESET;
    end else begin
      o_status[STB_MEAS] <= !fl_meas_reg;
      o_status[STB_TRIG] <= !fl_trig_reg;
      o_status[STB_ARM] <= !fl_arm_reg;
      o_status[STB_ANA] <= !fl_ana_reg;
      o_status[5:4] <= 2'b11;
      o_status[STB_SRQ] <= o_irq_req;
      o_status[STB_REC] <= !fl_rec_reg;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/pta_pkg.sv */
// Package for the pulse timing analyzer with its interrupt selector.
// Assumes one core clock and a sample memory with one cycle read latency.
`default_nettype none
package pta_pkg;

  localparam int SAMPLE_W = 16;
  localparam int ADDR_W = 18;
  localparam logic [ADDR_W:0] MEM_DEPTH = 19'h4_0000;
  localparam int VAL_W = 32;
  localparam int SUM_W = 48;
  localparam int CNT_W = 19;
  localparam logic [11:0] VAL_LIMIT = 12'h7D0;
  localparam logic [6:0] DUTY_SCALE = 7'h64;
  localparam logic [5:0] DIV_STEPS = 6'h30;
  // Sample rate used to turn periods into frequencies; not given anywhere
  localparam logic [VAL_W-1:0] SAMPLE_RATE_HZ = 32'h0098_9680;
  localparam logic [7:0] DELIM_RESET = 8'h3B;

  // Status byte: active low except the service request bit
  localparam int STB_MEAS = 0;
  localparam int STB_TRIG = 1;
  localparam int STB_ARM = 2;
  localparam int STB_ANA = 3;
  localparam int STB_SRQ = 6;
  localparam int STB_REC = 7;
  localparam logic [7:0] STB_RESET = 8'hBF;

  typedef enum logic [2:0] {
    PTA_SEL_HIGH, PTA_SEL_LOW, PTA_SEL_PERIOD, PTA_SEL_FREQ, PTA_SEL_DUTY
  } pta_sel_t;

  typedef enum logic [2:0] {
    PTA_IRQ_ARMED, PTA_IRQ_ANALYSIS, PTA_IRQ_DISABLE, PTA_IRQ_MEAS,
    PTA_IRQ_RECORD, PTA_IRQ_TRIG
  } pta_irq_cond_t;

  typedef struct packed {
    pta_sel_t sel;
    logic per_value;
    logic record_form;
    logic [15:0] record_num;
    logic count_given;
    logic [CNT_W-1:0] count;
    logic start_given;
    logic signed [ADDR_W:0] start;
  } pta_cmd_t;

  typedef struct packed {
    logic [VAL_W-1:0] max;
    logic [VAL_W-1:0] min;
    logic [VAL_W-1:0] avg;
    logic [CNT_W-1:0] count;
  } pta_result_t;

endpackage
`default_nettype wire

/* File: test/pta_chk.sv */
// Port checker for the pulse timing analyzer and its interrupt selector.
// Assumes one clock domain and single-cycle command and event pulses.
`default_nettype none
module pta_chk
  import pta_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Analysis
  input wire logic i_cmd_start,
  input wire logic [7:0] i_delimiter,
  input wire logic i_delimiter_wr,
  input wire logic o_mem_rd,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [7:0] o_val_delim,
  // Interrupt
  input wire logic i_irq_sel_wr,
  input wire logic i_irq_sel_given,
  input wire pta_pkg::pta_irq_cond_t i_irq_sel,
  input wire logic i_trigger_cmd,
  input wire logic i_ext_arm_prog,
  input wire logic i_ext_arm,
  input wire logic i_ev_triggered,
  input wire logic i_ev_meas_done,
  input wire logic i_ev_record_done,
  input wire logic i_irq_ack,
  input wire logic o_irq_req,
  input wire logic [7:0] o_status
);
  timeunit 1ns;
  timeprecision 1ps;
  pta_irq_cond_t cond_reg;
  logic en_reg;
  logic ev_hit;
  logic arm_ok;

  // Shadow of the selected condition and its trigger enable
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cond_reg <= PTA_IRQ_DISABLE;
      en_reg <= 1'b0;
    end else if (i_irq_sel_wr) begin
      cond_reg <= i_irq_sel_given ? i_irq_sel : PTA_IRQ_MEAS;
      en_reg <= 1'b0;
    end else if (i_trigger_cmd) begin
      en_reg <= 1'b1;
    end
  end

  assign ev_hit = (en_reg && ((cond_reg == PTA_IRQ_TRIG && i_ev_triggered) ||
    (cond_reg == PTA_IRQ_MEAS && i_ev_meas_done) ||
    (cond_reg == PTA_IRQ_RECORD && i_ev_record_done))) ||
    (cond_reg == PTA_IRQ_ANALYSIS && o_done);
  // Armed timing is loose, so it only excuses a rise or a request kept over acknowledge
  assign arm_ok = cond_reg == PTA_IRQ_ARMED && (en_reg || i_trigger_cmd) &&
    (!i_ext_arm_prog || i_ext_arm);

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence s_start;
    i_cmd_start && !o_busy && !o_done;
  endsequence
  // Busy is registered from the fetch state, so it trails the first read
  sequence s_first_read;
    o_mem_rd ##1 o_busy;
  endsequence

  start_walk_a: assert property (s_start |=> s_first_read)
    else $error("accepted start did not read memory");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done lasted more than one cycle");
  done_idle_a: assert property (o_done |-> !o_busy && !o_mem_rd)
    else $error("done while still busy");
  delim_set_a: assert property (i_delimiter_wr |=>
    o_val_delim == $past(i_delimiter))
    else $error("delimiter not taken");
  irq_hold_a: assert property (o_irq_req && !i_irq_ack |=> o_irq_req)
    else $error("request dropped without acknowledge");
  irq_clear_a: assert property (o_irq_req && i_irq_ack && !ev_hit &&
    !arm_ok |=> !o_irq_req)
    else $error("request stayed after acknowledge");
  irq_cause_a: assert property ($rose(o_irq_req) |->
    $past(ev_hit || arm_ok))
    else $error("request without selected enabled condition");
  irq_fire_a: assert property (ev_hit |=> o_irq_req)
    else $error("selected condition gave no request");
  stb_fixed_a: assert property (o_status[5:4] == 2'b11)
    else $error("status bits 5 and 4 not high");
  stb_srq_a: assert property (o_status[STB_SRQ] == $past(o_irq_req))
    else $error("status service bit does not follow request");
  stb_trig_a: assert property ($rose(o_irq_req) &&
    cond_reg == PTA_IRQ_TRIG |-> ##[0:1] !o_status[STB_TRIG])
    else $error("triggered status bit not low");
endmodule

bind pta_analyzer pta_chk i_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cmd_start(i_cmd_start),
  .i_delimiter(i_delimiter), .i_delimiter_wr(i_delimiter_wr),
  .o_mem_rd(o_mem_rd), .o_busy(o_busy), .o_done(o_done),
  .o_val_delim(o_val_delim), .i_irq_sel_wr(i_irq_sel_wr),
  .i_irq_sel_given(i_irq_sel_given), .i_irq_sel(i_irq_sel),
  .i_trigger_cmd(i_trigger_cmd), .i_ext_arm_prog(i_ext_arm_prog),
  .i_ext_arm(i_ext_arm), .i_ev_triggered(i_ev_triggered),
  .i_ev_meas_done(i_ev_meas_done), .i_ev_record_done(i_ev_record_done),
  .i_irq_ack(i_irq_ack), .o_irq_req(o_irq_req), .o_status(o_status)
);
`default_nettype wire

/* File: test/pta_mem_model.sv */
// Sample memory beside the analyzer, one cycle read latency.
// Assumes reads are strobed; holds a pulse train of widths 3, 4 and 5.
`default_nettype none
module pta_mem_model (
  // Clock
  input wire logic i_core_clk,
  // Read port
  input wire logic i_mem_rd,
  input wire logic [pta_pkg::ADDR_W-1:0] i_mem_addr,
  output logic signed [pta_pkg::SAMPLE_W-1:0] o_mem_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import pta_pkg::*;

  // High just above zero, low at zero or far below, so a midpoint
  // reference would misread the zero samples
  function automatic logic signed [SAMPLE_W-1:0] sample(
      input logic [ADDR_W-1:0] a);
    int w;
    w = 3 + (a / 10) % 3;
    if (a % 10 < w)
      return 16'h0001;
    return a[0] ? 16'hF800 : 16'h0000;
  endfunction

  initial o_mem_data = 16'h0000;
  // Unread cycles show changing data, never a stale sample
  always @(posedge i_core_clk) begin
    if (i_mem_rd)
      o_mem_data <= sample(i_mem_addr);
    else
      o_mem_data <= ~o_mem_data;
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the pulse timing analyzer.
// Assumes the memory model's fixed pulse train; inputs move on falling edges.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pta_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  // 0 trig, 1 meas, 2 record, 3 trigger cmd, 4 ack, 5 sel, 6 delim, 7 start
  logic [7:0] ev = 8'h00;
  pta_cmd_t cmd = '0;
  logic [7:0] delim = 8'h00;
  logic [ADDR_W-1:0] oldest = '0;
  logic [ADDR_W-1:0] rec_size = '0;
  logic sel_given = 1'b1;
  pta_irq_cond_t sel = PTA_IRQ_DISABLE;
  logic ext_prog = 1'b0;
  logic ext_arm = 1'b0;
  logic [ADDR_W-1:0] mem_addr;
  logic mem_rd;
  logic signed [SAMPLE_W-1:0] mem_data;
  logic busy, done, val_valid, irq;
  pta_result_t res;
  logic [VAL_W-1:0] val_data;
  logic [7:0] val_delim, status;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] vals[$];
  logic [31:0] mx[5] = '{32'h5, 32'h7, 32'hA, 32'h000F_4240, 32'h32};
  logic [31:0] mn[5] = '{32'h3, 32'h5, 32'hA, 32'h000F_4240, 32'h1E};
  logic [31:0] av[5] = '{32'h4, 32'h6, 32'hA, 32'h000F_4240, 32'h28};
  logic [31:0] ct[5] = '{32'h4, 32'h3, 32'h3, 32'h3, 32'h3};
  logic [31:0] hv[4] = '{32'h4, 32'h5, 32'h3, 32'h4};
  pta_irq_cond_t cc[4] = '{PTA_IRQ_TRIG, PTA_IRQ_MEAS, PTA_IRQ_RECORD,
    PTA_IRQ_ARMED};
  int pre[4] = '{0, 1, 2, 1};
  int sb[4] = '{STB_TRIG, STB_MEAS, STB_REC, STB_ARM};

  pta_analyzer i_dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cmd_start(ev[7]),
    .i_cmd(cmd), .i_delimiter(delim), .i_delimiter_wr(ev[6]),
    .i_oldest_addr(oldest), .i_record_size(rec_size),
    .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .i_mem_data(mem_data),
    .o_busy(busy), .o_done(done), .o_result(res), .o_val_valid(val_valid),
    .o_val_data(val_data), .o_val_delim(val_delim), .i_irq_sel_wr(ev[5]),
    .i_irq_sel_given(sel_given), .i_irq_sel(sel), .i_trigger_cmd(ev[3]),
    .i_ext_arm_prog(ext_prog), .i_ext_arm(ext_arm),
    .i_ev_triggered(ev[0]), .i_ev_meas_done(ev[1]),
    .i_ev_record_done(ev[2]), .i_irq_ack(ev[4]), .o_irq_req(irq),
    .o_status(status)
  );
  pta_mem_model i_mem (
    .i_core_clk(i_core_clk), .i_mem_rd(mem_rd), .i_mem_addr(mem_addr),
    .o_mem_data(mem_data)
  );

  always #20 i_core_clk = ~i_core_clk;

  task stop_test;
    $display("miscompares=%0d samples_checked=%0d", miscompares,
      samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task pulse(input int k);
    @(negedge i_core_clk) ev[k] = 1'b1;
    @(negedge i_core_clk) ev[k] = 1'b0;
  endtask

  task select(input pta_irq_cond_t c, input logic g);
    sel = c;
    sel_given = g;
    pulse(5);
  endtask

  // Analysis done also raises the request, since the condition is set
  task analyze(input pta_sel_t s, input logic [CNT_W-1:0] n,
      input logic sg, input logic [ADDR_W:0] st, input logic rf,
      input logic [31:0] emx, emn, eav, ecnt);
    int i;
    cmd.sel = s;
    cmd.per_value = 1'b1;
    cmd.count_given = 1'b1;
    cmd.count = n;
    cmd.start_given = sg;
    cmd.start = st;
    cmd.record_form = rf;
    cmd.record_num = 16'h0001;
    vals.delete();
    pulse(7);
    for (i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(negedge i_core_clk);
      if (val_valid === 1'b1)
        vals.push_back(val_data);
    end
    if (i == 3000) begin
      miscompares++;
      stop_test();
    end
    chk(res.max, emx);
    chk(res.min, emn);
    chk(res.avg, eav);
    chk(32'(res.count), ecnt);
    chk(32'(vals.size()), ecnt);
    // Status lags the request by one cycle
    cyc(2);
    chk(32'(irq), 32'h1);
    chk(32'(status[STB_ANA]), 32'h0);
    pulse(4);
    chk(32'(irq), 32'h0);
  endtask

  initial begin
    cyc(2);
    chk(32'(status), 32'hBF);
    chk(32'(val_delim), 32'h3B);
    chk(32'(irq), 32'h0);
    i_reset = 1'b0;
    delim = 8'h2C;
    pulse(6);
    chk(32'(val_delim), 32'h2C);
    oldest = 18'h0_0005;
    // Record size off the 30-sample pattern, so a lost base shows
    rec_size = 18'h0_0014;
    select(PTA_IRQ_ANALYSIS, 1'b1);
    for (int i = 0; i < 5; i++)
      analyze(pta_sel_t'(i), 19'h0_0028, 1'b0, 19'h0_0000, 1'b0, mx[i],
        mn[i], av[i], ct[i]);
    oldest = 18'h0_0064;
    analyze(PTA_SEL_HIGH, 19'h0_0028, 1'b1, 19'h0_0005, 1'b0, 32'h5,
      32'h3, 32'h4, 32'h4);
    for (int i = 0; i < 4; i++)
      chk(vals[i], hv[i]);
    analyze(PTA_SEL_HIGH, 19'h0_000A, 1'b1, 19'h0_0005, 1'b1, 32'h3,
      32'h3, 32'h3, 32'h1);
    analyze(PTA_SEL_HIGH, 19'h0_0001, 1'b0, 19'h0_0000, 1'b0, 32'h0,
      32'h0, 32'h0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      select(cc[k], 1'b1);
      pulse(pre[k]);
      cyc(3);
      chk(32'(irq), 32'h0);
      pulse(3);
      if (k < 3)
        pulse(k);
      cyc(3);
      chk(32'(irq), 32'h1);
      cyc(4);
      chk(32'(irq), 32'h1);
      chk(32'(status[sb[k]]), 32'h0);
      chk(32'(status[STB_SRQ]), 32'h1);
      pulse(4);
      chk(32'(irq), 32'h0);
    end
    select(PTA_IRQ_ARMED, 1'b1);
    pulse(1);
    ext_prog = 1'b1;
    pulse(3);
    cyc(3);
    chk(32'(irq), 32'h0);
    ext_arm = 1'b1;
    cyc(3);
    chk(32'(irq), 32'h1);
    pulse(4);
    ext_prog = 1'b0;
    ext_arm = 1'b0;
    select(PTA_IRQ_TRIG, 1'b0);
    pulse(3);
    pulse(0);
    cyc(3);
    chk(32'(irq), 32'h0);
    pulse(1);
    cyc(2);
    chk(32'(irq), 32'h1);
    pulse(4);
    select(PTA_IRQ_DISABLE, 1'b1);
    pulse(3);
    pulse(0);
    pulse(1);
    pulse(2);
    cyc(3);
    chk(32'(irq), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
